// File: rtl/flash_sec_defines.svh
// Constants for the flash security and configuration block.
// Assumes a byte-wide register view carried on a 32-bit Wishbone bus.
`ifndef FLASH_SEC_DEFINES_SVH
`define FLASH_SEC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_OPTION_OFF   6'h00
`define REG_CONFIG_OFF   6'h04
`define REG_PROTECT_OFF  6'h08
`define REG_STATUS_OFF   6'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OPT_KEY_ALLOW_BIT 7
`define OPT_LAYOUT_BIT    5
`define OPT_SEC_LSB       0
`define CFG_PAGE_BIT      6
`define CFG_KEYWR_BIT     5
`define CFG_WMASK         8'h60
`define STA_PUMP_BIT      0
`define STA_SECURED_BIT   1
`define STA_KEYFILL_BIT   2
`define STA_KEYFAIL_BIT   3

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define SEC_OPEN          2'h2
`define CFG_RESET         8'h00
`define KEY_BASE_ADR      13'h1ff6
`define KEY_BYTES         8

`endif

// File: rtl/flash_sec_pkg.sv
// Types for the flash security and configuration block.
// Assumes the defines header is compiled alongside.
package flash_sec_pkg;

	// Charge pump controller states
	typedef enum logic [1:0] {
		PUMP_OFF,
		PUMP_ON,
		PUMP_HOLD
	} pump_state_t;

	// Two-bit security code
	typedef logic [1:0] sec_code_t;

endpackage

// File: rtl/pump_control.sv
// Charge pump enable for the flash array.
// Assumes one-cycle command launch and done pulses from the engine.
`timescale 1ns/1ps
module pump_control (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic launch_i,
	input  wire logic burst_i,
	input  wire logic done_i,
	input  wire logic next_pending_i,
	output logic      pump_on_o
);

	flash_sec_pkg::pump_state_t state_reg;
	flash_sec_pkg::pump_state_t state_next;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			flash_sec_pkg::PUMP_OFF: begin
				if (launch_i)
					state_next = flash_sec_pkg::PUMP_ON; // see R2
			end
			flash_sec_pkg::PUMP_ON: begin
				if (done_i) begin
					// Burst keeps high voltage between bytes
					if (burst_i && next_pending_i)
						state_next = flash_sec_pkg::PUMP_HOLD; // see R1
					else
						state_next = flash_sec_pkg::PUMP_OFF; // see R2
				end
			end
			flash_sec_pkg::PUMP_HOLD: begin
				if (launch_i)
					state_next = flash_sec_pkg::PUMP_ON; // see R1
				else if (!next_pending_i)
					state_next = flash_sec_pkg::PUMP_OFF; // see R13
			end
			default: state_next = flash_sec_pkg::PUMP_OFF;
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			state_reg <= flash_sec_pkg::PUMP_OFF;
		else
			state_reg <= state_next;
	end

	// Pump on in both active states
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pump_on_o <= 1'b0;
		else
			pump_on_o <= (state_next != flash_sec_pkg::PUMP_OFF);
	end

endmodule

// File: rtl/key_compare.sv
// Backdoor key comparator: collects key bytes, compares once full.
// Assumes stored key arrives as a stable vector, byte 0 in low bits.
`timescale 1ns/1ps
`include "flash_sec_defines.svh"
module key_compare #(
	parameter int NBYTES = `KEY_BYTES
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   wr_i,
	input  wire logic [2:0]             idx_i,
	input  wire logic [7:0]             data_i,
	input  wire logic [NBYTES*8-1:0]    stored_key_i,
	output logic                        match_o,
	output logic                        fail_o,
	output logic                        full_o
);

	logic [7:0]        key_reg [NBYTES];
	logic [NBYTES-1:0] fill_reg;
	logic              all_filled;
	logic              same;

	assign all_filled = &fill_reg;
	assign full_o     = all_filled;

	// Byte storage
	always_ff @(posedge clk_i) begin
		if (wr_i)
			key_reg[idx_i] <= data_i;
	end

	// Fill tracking, cleared after each compare
	always_ff @(posedge clk_i) begin
		if (rst_i || all_filled)
			fill_reg <= '0;
		else if (wr_i)
			fill_reg[idx_i] <= 1'b1;
	end

	// Byte-wise equality
	always_comb begin
		same = 1'b1;
		for (int i = 0; i < NBYTES; i++)
			if (key_reg[i] != stored_key_i[i*8 +: 8])
				same = 1'b0;
	end

	// One-cycle result pulses
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_o <= 1'b0;
			fail_o  <= 1'b0;
		end else begin
			match_o <= all_filled && same;
			fail_o  <= all_filled && !same;
		end
	end

endmodule

// File: rtl/flash_security_config.sv
// Flash and EEPROM security and configuration control.
// Assumes a Wishbone classic master and a byte CPU access port on clk_i.
//
// Summary of operation
// R1: Burst programming keeps array high voltage on between bytes.
// R2: Normal command turns charge pump on while running, off when done.
// R3: Sector mode bit 5 picks split (4-byte) or whole-page (8-byte) layout.
// R4: Only security code 1:0 is unsecured; all others are secured.
// R5: While secured, block memory access from any unsecured source or debug.
// R6: Key match or blank check pass forces security code to 1:0.
// R7: Page select bit 6 picks foreground EEPROM page; other is hidden.
// R8: Key enable clear: key-range writes start a program or erase command.
// R9: Key enable bit 5 set: key-range writes go to key comparator.
// R10: Reset copies stored protect and option bytes to working registers.
// R11: Backdoor key unlocks only when stored key-allow bit is 1.
// R12: Key bytes come only from secure code, never from debug.
// R13: Software should launch next burst byte early to keep pump on.
`timescale 1ns/1ps
`include "flash_sec_defines.svh"
module flash_security_config #(
	parameter int KEYN = `KEY_BYTES
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone classic slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [5:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic [31:0]               wb_dat_o,
	output logic                      wb_ack_o,
	output logic                      wb_err_o,
	// Nonvolatile contents
	input  wire logic [7:0]           stored_option_byte_i,
	input  wire logic [7:0]           stored_protect_byte_i,
	input  wire logic [KEYN*8-1:0]    backdoor_compare_key_i,
	// CPU memory access
	input  wire logic                 cpu_valid_i,
	input  wire logic                 cpu_we_i,
	input  wire logic [15:0]          cpu_adr_i,
	input  wire logic [7:0]           cpu_dat_i,
	input  wire logic                 cpu_secure_src_i,
	input  wire logic                 cpu_debug_i,
	input  wire logic                 cpu_mem_hit_i,
	output logic                      access_block_o,
	// Command engine
	output logic                      cmd_first_write_o,
	output logic [15:0]               cmd_adr_o,
	output logic [7:0]                cmd_dat_o,
	input  wire logic                 cmd_launch_i,
	input  wire logic                 cmd_burst_i,
	input  wire logic                 cmd_done_i,
	input  wire logic                 cmd_next_pending_i,
	input  wire logic                 blank_ok_i,
	output logic                      pump_on_o,
	// EEPROM mapping and security state
	output logic                      eeprom_page_pick_o,
	output logic                      eeprom_page_layout_o,
	output logic                      secured_o
);

	// ----------------------------------------------------------------
	// Working registers
	// ----------------------------------------------------------------
	logic [7:0]               option_working_reg;
	logic [7:0]               protect_working_reg;
	logic [7:0]               memory_config_reg;
	logic                     load_pend_reg;
	logic                     key_fail_reg;
	flash_sec_pkg::sec_code_t lock_state_code;

	logic wb_req;
	logic wb_wr;
	logic adr_mapped;
	logic key_hit;
	logic key_wr;
	logic key_match;
	logic key_fail;
	logic key_full;
	logic key_write_enable;
	logic backdoor_key_allow;
	logic unlock;

	assign lock_state_code = option_working_reg[`OPT_SEC_LSB +: 2];
	assign key_write_enable = memory_config_reg[`CFG_KEYWR_BIT];
	assign backdoor_key_allow = option_working_reg[`OPT_KEY_ALLOW_BIT];

	// Security decode
	assign secured_o = (lock_state_code != `SEC_OPEN); // see R4

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Request and decode
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign wb_wr  = wb_req && wb_we_i;
	always_comb begin
		case (wb_adr_i)
			`REG_OPTION_OFF,
			`REG_CONFIG_OFF,
			`REG_PROTECT_OFF,
			`REG_STATUS_OFF: adr_mapped = 1'b1;
			default:         adr_mapped = 1'b0;
		endcase
	end

	// Answer one cycle after request, dropped the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req && adr_mapped;
			wb_err_o <= wb_req && !adr_mapped;
		end
	end

	// Read data
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_req) begin
			wb_dat_o <= 32'h0000_0000;
			case (wb_adr_i)
				`REG_OPTION_OFF:  wb_dat_o[7:0] <= option_working_reg;
				`REG_CONFIG_OFF:  wb_dat_o[7:0] <= memory_config_reg;
				`REG_PROTECT_OFF: wb_dat_o[7:0] <= protect_working_reg;
				`REG_STATUS_OFF: begin
					wb_dat_o[`STA_PUMP_BIT]    <= pump_on_o;
					wb_dat_o[`STA_SECURED_BIT] <= secured_o;
					wb_dat_o[`STA_KEYFILL_BIT] <= key_full;
					wb_dat_o[`STA_KEYFAIL_BIT] <= key_fail_reg;
				end
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration register, only page and key bits writable
	always_ff @(posedge clk_i) begin
		if (rst_i)
			memory_config_reg <= `CFG_RESET;
		else if (wb_wr && wb_sel_i[0] && wb_adr_i == `REG_CONFIG_OFF)
			memory_config_reg <= wb_dat_i[7:0] & `CFG_WMASK;
	end

	// ----------------------------------------------------------------
	// Reset load of working registers
	// ----------------------------------------------------------------
	// Load pending flag, taken the cycle after reset release
	always_ff @(posedge clk_i) begin
		if (rst_i)
			load_pend_reg <= 1'b1;
		else
			load_pend_reg <= 1'b0;
	end

	// Protect copy
	always_ff @(posedge clk_i) begin
		if (rst_i)
			protect_working_reg <= 8'h00;
		else if (load_pend_reg)
			protect_working_reg <= stored_protect_byte_i; // see R10
	end

	// Option copy and unlock override
	assign unlock = (key_match && backdoor_key_allow) // see R11
			|| blank_ok_i;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			option_working_reg <= 8'h00;
		else if (load_pend_reg)
			option_working_reg <= stored_option_byte_i; // see R10
		else if (unlock)
			option_working_reg[`OPT_SEC_LSB +: 2] <= `SEC_OPEN; // see R6
	end

	// ----------------------------------------------------------------
	// CPU access routing
	// ----------------------------------------------------------------
	// Block array access from untrusted masters while secured
	assign access_block_o = secured_o && cpu_valid_i && cpu_mem_hit_i
			&& (!cpu_secure_src_i || cpu_debug_i); // see R5

	// Key window decode
	assign key_hit = cpu_valid_i && cpu_we_i
			&& (cpu_adr_i[15:3] == `KEY_BASE_ADR);

	// Key bytes only from secure code, never debug
	assign key_wr = key_hit && key_write_enable // see R9
			&& cpu_secure_src_i && !cpu_debug_i; // see R12

	// Command engine first write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_first_write_o <= 1'b0;
			cmd_adr_o         <= 16'h0000;
			cmd_dat_o         <= 8'h00;
		end else begin
			cmd_first_write_o <= key_hit && !key_write_enable; // see R8
			if (key_hit && !key_write_enable) begin
				cmd_adr_o <= cpu_adr_i;
				cmd_dat_o <= cpu_dat_i;
			end
		end
	end

	// Key compare result, sticky until next good match or reset
	always_ff @(posedge clk_i) begin
		if (rst_i || key_match)
			key_fail_reg <= 1'b0;
		else if (key_fail)
			key_fail_reg <= 1'b1;
	end

	key_compare #(
		.NBYTES (KEYN)
	) u_key (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.wr_i         (key_wr), // see R9
		.idx_i        (cpu_adr_i[2:0]),
		.data_i       (cpu_dat_i),
		.stored_key_i (backdoor_compare_key_i),
		.match_o      (key_match),
		.fail_o       (key_fail),
		.full_o       (key_full)
	);

	// ----------------------------------------------------------------
	// Charge pump and EEPROM mapping
	// ----------------------------------------------------------------
	pump_control u_pump (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.launch_i       (cmd_launch_i),
		.burst_i        (cmd_burst_i),
		.done_i         (cmd_done_i),
		.next_pending_i (cmd_next_pending_i),
		.pump_on_o      (pump_on_o)
	);

	// Page pick from configuration register, layout from option working register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eeprom_page_pick_o   <= 1'b0;
			eeprom_page_layout_o <= 1'b0;
		end else begin
			eeprom_page_pick_o   <= memory_config_reg[`CFG_PAGE_BIT]; // see R7
			eeprom_page_layout_o <= option_working_reg[`OPT_LAYOUT_BIT]; // see R3
		end
	end

endmodule

// File: tb/flash_security_config_asserts.sv
// Port-level checker for the flash security block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module flash_security_config_asserts #(
	parameter int KEYN = 8
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        cpu_valid_i,
	input wire logic        cpu_we_i,
	input wire logic [15:0] cpu_adr_i,
	input wire logic [7:0]  cpu_dat_i,
	input wire logic        cpu_secure_src_i,
	input wire logic        cpu_debug_i,
	input wire logic        cpu_mem_hit_i,
	input wire logic        access_block_o,
	input wire logic        cmd_first_write_o,
	input wire logic [15:0] cmd_adr_o,
	input wire logic [7:0]  cmd_dat_o,
	input wire logic        cmd_launch_i,
	input wire logic        cmd_burst_i,
	input wire logic        cmd_done_i,
	input wire logic        cmd_next_pending_i,
	input wire logic        blank_ok_i,
	input wire logic        pump_on_o,
	input wire logic        eeprom_page_pick_o,
	input wire logic        eeprom_page_layout_o,
	input wire logic        secured_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Register read answers
	sequence s_opt_read;
		wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 6'h00;
	endsequence
	sequence s_cfg_read;
		wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 6'h04;
	endsequence

	AST_SEC_DECODE: assert property (s_opt_read |->
		secured_o == (wb_dat_o[1:0] != 2'h2)) else $error("lock decode");
	AST_LAYOUT: assert property (s_opt_read |->
		eeprom_page_layout_o == wb_dat_o[5]) else $error("layout level");
	AST_PAGE: assert property (s_cfg_read |->
		eeprom_page_pick_o == wb_dat_o[6]) else $error("page level");
	AST_BLOCK: assert property (cpu_valid_i && cpu_mem_hit_i &&
		secured_o && (!cpu_secure_src_i || cpu_debug_i) |-> access_block_o)
		else $error("access not blocked");
	AST_OPEN: assert property (!secured_o |-> !access_block_o)
		else $error("blocked while open");
	AST_CMD: assert property (cmd_first_write_o |->
		$past(cpu_valid_i && cpu_we_i && cpu_adr_i[15:3] == 13'h1ff6)
		&& cmd_adr_o == $past(cpu_adr_i) && cmd_dat_o == $past(cpu_dat_i))
		else $error("command start");
	AST_PUMP_ON: assert property (cmd_launch_i |=> pump_on_o)
		else $error("pump not on");
	AST_PUMP_OFF: assert property (cmd_done_i && !cmd_launch_i &&
		!(cmd_burst_i && cmd_next_pending_i) |=> !pump_on_o)
		else $error("pump not off");
	AST_BURST: assert property (cmd_done_i && cmd_burst_i &&
		cmd_next_pending_i |=> pump_on_o) else $error("burst pump off");
	AST_BLANK: assert property (blank_ok_i |=> !secured_o [*3])
		else $error("blank check unlock");
endmodule

bind flash_security_config flash_security_config_asserts #(.KEYN(KEYN)) chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_valid_i(cpu_valid_i),
	.cpu_we_i(cpu_we_i), .cpu_adr_i(cpu_adr_i), .cpu_dat_i(cpu_dat_i),
	.cpu_secure_src_i(cpu_secure_src_i), .cpu_debug_i(cpu_debug_i),
	.cpu_mem_hit_i(cpu_mem_hit_i), .access_block_o(access_block_o),
	.cmd_first_write_o(cmd_first_write_o), .cmd_adr_o(cmd_adr_o),
	.cmd_dat_o(cmd_dat_o), .cmd_launch_i(cmd_launch_i),
	.cmd_burst_i(cmd_burst_i), .cmd_done_i(cmd_done_i),
	.cmd_next_pending_i(cmd_next_pending_i), .blank_ok_i(blank_ok_i),
	.pump_on_o(pump_on_o), .eeprom_page_pick_o(eeprom_page_pick_o),
	.eeprom_page_layout_o(eeprom_page_layout_o), .secured_o(secured_o));

// File: tb/cpu_side_model.sv
// CPU and debug side model driving the memory access port.
// Assumes its tasks are called right after a rising edge.
`timescale 1ns/1ps
module cpu_side_model (
	input  wire logic  clk_i,
	input  wire logic  blk_i,
	output logic       valid_o = 1'b0,
	output logic       we_o = 1'b0,
	output logic [15:0] adr_o = 16'h0000,
	output logic [7:0] dat_o = 8'h00,
	output logic       secure_o = 1'b1,
	output logic       debug_o = 1'b0,
	output logic       hit_o = 1'b0
);
	// Byte writes one per cycle, then a released idle cycle
	task automatic put(input logic [15:0] base, input logic [63:0] d,
		input int n, input logic dbg);
		for (int i = 0; i < n; i++) begin
			valid_o <= 1'b1;
			we_o <= 1'b1;
			hit_o <= 1'b1;
			secure_o <= 1'b1;
			debug_o <= dbg;
			adr_o <= base + 16'(i);
			dat_o <= d[8*i +: 8];
			@(posedge clk_i);
		end
		valid_o <= 1'b0;
		hit_o <= 1'b0;
		adr_o <= ~adr_o;
		dat_o <= ~dat_o;
		@(posedge clk_i);
	endtask

	// One memory read, returning the block level seen
	task automatic look(input logic sec, input logic dbg, output logic b);
		valid_o <= 1'b1;
		we_o <= 1'b0;
		hit_o <= 1'b1;
		secure_o <= sec;
		debug_o <= dbg;
		@(posedge clk_i);
		b = blk_i;
		valid_o <= 1'b0;
		hit_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

// File: tb/flash_security_config_tb.sv
// Self-checking bench for the flash security block.
// Assumes the design, checker and side model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module flash_security_config_tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
	logic        we = 1'b0, burst = 1'b0, pend = 1'b0, blank = 1'b0, b;
	logic [1:0]  ev = 2'b00;
	logic [5:0]  adr = 6'h00;
	logic [31:0] wdat = 32'h0000_0000, rdat;
	logic        ack, err, blk, cfw, pump, pick, layout, secured;
	logic        cv, cw, cs, cd, ch;
	logic [7:0]  o = 8'h80, sprot = 8'h00, cdat, cdb;
	logic [15:0] ca, cadr;
	logic [63:0] key = 64'h0000_0000_0000_0000;
	logic [33:0] q[$];
	logic [23:0] cq[$];
	int          n_mismatch = 0, cmp_count = 0;
	localparam logic [33:0] WR = {2'b00, 32'h0000_0000};
	localparam logic [33:0] ER = {2'b01, 32'h0000_0000};

	flash_security_config #(.KEYN(8)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.stored_option_byte_i(o), .stored_protect_byte_i(sprot),
		.backdoor_compare_key_i(key), .cpu_valid_i(cv), .cpu_we_i(cw),
		.cpu_adr_i(ca), .cpu_dat_i(cdb), .cpu_secure_src_i(cs),
		.cpu_debug_i(cd), .cpu_mem_hit_i(ch), .access_block_o(blk),
		.cmd_first_write_o(cfw), .cmd_adr_o(cadr), .cmd_dat_o(cdat),
		.cmd_launch_i(ev[0]), .cmd_burst_i(burst), .cmd_done_i(ev[1]),
		.cmd_next_pending_i(pend), .blank_ok_i(blank), .pump_on_o(pump),
		.eeprom_page_pick_o(pick), .eeprom_page_layout_o(layout),
		.secured_o(secured));
	cpu_side_model cpu_u (.clk_i(clk_i), .blk_i(blk), .valid_o(cv),
		.we_o(cw), .adr_o(ca), .dat_o(cdb), .secure_o(cs), .debug_o(cd),
		.hit_o(ch));

	// Clock
	initial forever #5 clk_i = ~clk_i;

	function automatic logic [33:0] rd(input logic [7:0] v);
		return {2'b10, 24'h00_0000, v};
	endfunction

	// Compare each answer against the oldest note
	always @(posedge clk_i) begin
		if (ack === 1'b1 || err === 1'b1) begin
			`CHK(err, q[0][32])
			if (q[0][33]) `CHK(rdat, q[0][31:0])
			void'(q.pop_front());
		end
		if (cfw === 1'b1) begin
			`CHK({cadr, cdat}, cq[0])
			void'(cq.pop_front());
		end
	end

	// One classic bus cycle, waiting for the answer
	task automatic wb(input logic w, input logic [5:0] a,
		input logic [7:0] d, input logic [33:0] e);
		int n;
		n = 0;
		q.push_back(e);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
		if (n >= 20) n_mismatch++;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic do_reset(input logic [7:0] v);
		o <= v;
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic fire(input logic [1:0] v);
		ev <= v;
		@(posedge clk_i);
		ev <= 2'b00;
		@(posedge clk_i);
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (5000) @(posedge clk_i);
		n_mismatch++;
		give_verdict();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h7738));
		// Random stimulus reaches the design by non-blocking assignment
		key <= {$urandom, $urandom};
		sprot <= 8'($urandom);
		for (int c = 0; c < 4; c++) begin
			do_reset({1'b1, 2'($urandom), 3'b000, 2'(c)});
			wb(1'b0, 6'h00, 8'h00, rd(o));
			wb(1'b0, 6'h08, 8'h00, rd(sprot));
			`CHK(secured, 1'(c != 2))
			`CHK(layout, o[5])
		end
		wb(1'b1, 6'h00, 8'hff, WR);
		wb(1'b0, 6'h00, 8'h00, rd(o));
		wb(1'b0, 6'h10, 8'h00, ER);
		wb(1'b1, 6'h3c, 8'h01, ER);
		wb(1'b1, 6'h04, 8'hff, WR);
		wb(1'b0, 6'h04, 8'h00, rd(8'h60));
		`CHK(pick, 1'b1)
		wb(1'b1, 6'h04, 8'h00, WR);
		`CHK(pick, 1'b0)
		for (int i = 0; i < 8; i++) cq.push_back({16'hffb0 + 16'(i), key[8*i +: 8]});
		cpu_u.put(16'hffb0, key, 8, 1'b0);
		cpu_u.put(16'hffb8, key, 1, 1'b0);
		cpu_u.look(1'b0, 1'b0, b);
		`CHK(b, 1'b1)
		cpu_u.look(1'b1, 1'b1, b);
		`CHK(b, 1'b1)
		cpu_u.look(1'b1, 1'b0, b);
		`CHK(b, 1'b0)
		wb(1'b1, 6'h04, 8'h20, WR);
		cpu_u.put(16'hffb0, key, 8, 1'b1);
		cpu_u.put(16'hffb0, ~key, 8, 1'b0);
		repeat (5) @(posedge clk_i);
		`CHK(secured, 1'b1)
		wb(1'b0, 6'h0c, 8'h00, rd(8'h0a));
		cpu_u.put(16'hffb0, key, 8, 1'b0);
		repeat (3) @(posedge clk_i);
		`CHK(secured, 1'b0)
		cpu_u.look(1'b0, 1'b1, b);
		`CHK(b, 1'b0)
		wb(1'b0, 6'h00, 8'h00, rd({o[7:2], 2'b10}));
		do_reset({1'b0, o[6:2], 2'b00});
		wb(1'b1, 6'h04, 8'h20, WR);
		cpu_u.put(16'hffb0, key, 8, 1'b0);
		repeat (5) @(posedge clk_i);
		`CHK(secured, 1'b1)
		blank <= 1'b1;
		@(posedge clk_i);
		blank <= 1'b0;
		@(posedge clk_i);
		`CHK(secured, 1'b0)
		fire(2'b01);
		`CHK(pump, 1'b1)
		fire(2'b10);
		`CHK(pump, 1'b0)
		burst <= 1'b1;
		pend <= 1'b1;
		fire(2'b01);
		fire(2'b10);
		`CHK(pump, 1'b1)
		fire(2'b01);
		pend <= 1'b0;
		fire(2'b10);
		`CHK(pump, 1'b0)
		repeat (3) @(posedge clk_i);
		`CHK(q.size() + cq.size(), 0)
		give_verdict();
	end
endmodule
